// file: shared/scgwt_pkg.sv
/*
 Constants and carrier types for the smart card guard and wait timers.
 Assumes a 32-bit AXI4-Lite slave: register index times four is the byte address.
*/
package scgwt_pkg;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned IDX_W  = 16;
   // Register indexes; the byte address is four times the index
   localparam logic [15:0] IDX_BGT  = 16'hFE16;
   localparam logic [15:0] IDX_GLOW = 16'hFE17;
   localparam logic [15:0] IDX_BW3  = 16'hFE18;
   localparam logic [15:0] IDX_BW2  = 16'hFE19;
   localparam logic [15:0] IDX_BW1  = 16'hFE1A;
   localparam logic [15:0] IDX_BW0  = 16'hFE1B;
   localparam logic [15:0] IDX_CWH  = 16'hFE1C;
   localparam logic [15:0] IDX_CWL  = 16'hFE1D;
   localparam logic [15:0] IDX_ATH  = 16'hFE1F;
   localparam logic [15:0] IDX_ATL  = 16'hFE20;
   localparam logic [15:0] IDX_CTRL = 16'hFE30;
   localparam logic [15:0] IDX_STAT = 16'hFE31;
   // Field positions
   localparam int unsigned BGT_TOP_BIT  = 7;
   localparam int unsigned CTRL_T1_BIT  = 0;
   localparam int unsigned CTRL_RCV_BIT = 1;
   localparam int unsigned STAT_WAIT    = 0;
   localparam int unsigned STAT_CHR     = 1;
   localparam int unsigned STAT_ANS     = 2;
   // Reset values
   localparam logic [7:0] GLOW_RST = 8'h0C;
   localparam logic [7:0] BGT_RST  = 8'h10;
   localparam logic [7:0] BGT_MASK = 8'h9F;
   localparam logic [8:0] GUARD_T0_MIN = 9'h00C;
   localparam logic [8:0] GUARD_T1_MIN = 9'h00B;
   localparam logic [8:0] GUARD_SAT    = 9'h1FF;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic tx_start;
      logic rx_start;
      logic brk;
   } scgwt_evt_t;

   typedef struct packed {
      logic ans_to;
      logic chr_to;
      logic wait_to;
   } scgwt_flags_t;

   typedef enum logic [3:0] {
      ATR_IDLE  = 4'b0001,
      ATR_ARMED = 4'b0010,
      ATR_RUN   = 4'b0100,
      ATR_DONE  = 4'b1000
   } scgwt_atr_st_t;
endpackage : scgwt_pkg

// file: verilog/scgwt_timers.sv
/*
 Guard and wait timers of a smart card character interface, AXI4-Lite registers.
 Assumes character start events come from the UART on core_clk_i, and that the
 ETU clock arrives from the ETU divider asynchronously.
*/
//
// Operation
// - Hold each character until guard elapsed
// - Guard value nine bits, top bit elsewhere
// - T=0 guard at least 12 ETUs
// - T=1 guard at least 11 ETUs
// - T=0 break may delay next start
// - Wait limit 28 bits over four bytes
// - T=1 count last sent to first received
// - T=0 count between any two characters
// - Wait limit exceeded raises timeout request
// - Full 28-bit wait range programmable
// - Time received start edges, 16-bit limit
// - Same limit serves character and initial wait
// - Answer limit 16 bits, two bytes
// - Answer timer spans first character to expiry or disable
// - Answer timer armed only while enabled
// - Answer duration exceeded signals timeout
`timescale 1ns/10ps
module scgwt_timers #(
   parameter int unsigned ADDR_W = scgwt_pkg::ADDR_W
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 clk_en_i,
   input  wire logic                 etu_clk_i,
   input  wire scgwt_pkg::scgwt_evt_t evt_i,
   output logic                      tx_allow_o,
   output scgwt_pkg::scgwt_flags_t   flags_o,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   if (ADDR_W < scgwt_pkg::ADDR_W) begin : g_chk
      $error("ADDR_W too small for the register indexes");
   end

   function automatic logic reg_mapped(input logic [15:0] idx);
      case (idx)
         scgwt_pkg::IDX_BGT, scgwt_pkg::IDX_GLOW, scgwt_pkg::IDX_BW3,
         scgwt_pkg::IDX_BW2, scgwt_pkg::IDX_BW1, scgwt_pkg::IDX_BW0,
         scgwt_pkg::IDX_CWH, scgwt_pkg::IDX_CWL, scgwt_pkg::IDX_ATH,
         scgwt_pkg::IDX_ATL, scgwt_pkg::IDX_CTRL,
         scgwt_pkg::IDX_STAT: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : reg_mapped

   // Restart wins over a tick in the same cycle
   function automatic logic [28:0] tmr_next(input logic [28:0] c,
                                            input logic restart,
                                            input logic tick);
      if (restart) begin
         return 29'h0000000;
      end
      return c + {28'h0000000, tick};
   endfunction : tmr_next

   ////////////////////////////////////////////////////////////////////////////
   // ETU clock sampling

   logic etu_s1_q;
   logic etu_s2_q;
   logic etu_s3_q;
   logic etu_tick;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         etu_s1_q <= 1'b0;
         etu_s2_q <= 1'b0;
         etu_s3_q <= 1'b0;
      end else if (clk_en_i) begin
         etu_s1_q <= etu_clk_i;
         etu_s2_q <= etu_s1_q;
         etu_s3_q <= etu_s2_q;
      end
   end

   // Events arriving while frozen are dropped, so the UART must hold off too
   logic tx_go;
   logic rx_go;
   assign etu_tick = clk_en_i & etu_s2_q & ~etu_s3_q;
   assign tx_go    = clk_en_i & evt_i.tx_start;
   assign rx_go    = clk_en_i & evt_i.rx_start;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and bus slave

   logic [7:0]               guard_lo_q;
   logic [7:0]               bgt_q;
   logic [27:0]              bw_q;
   logic [15:0]              cw_q;
   logic [15:0]              at_q;
   logic [1:0]               ctrl_q;
   scgwt_pkg::scgwt_flags_t  flags_q;
   logic                     aw_have_q;
   logic                     w_have_q;
   logic [15:0]              aw_idx_q;
   logic [7:0]               w_data_q;
   logic                     w_lane_q;
   logic                     do_wr;
   logic                     wr_en;
   logic [31:0]              rd_mux;
   logic [15:0]              ar_idx;
   logic                     mode_t1;
   logic                     rcv_en;

   assign s_axi_awready = clk_en_i & ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = clk_en_i & ~w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = clk_en_i & ~s_axi_rvalid;
   assign do_wr   = clk_en_i & aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_en   = do_wr & w_lane_q;
   assign ar_idx  = s_axi_araddr[17:2];
   assign mode_t1 = ctrl_q[scgwt_pkg::CTRL_T1_BIT];
   assign rcv_en  = ctrl_q[scgwt_pkg::CTRL_RCV_BIT];

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_idx_q  <= 16'h0000;
         w_data_q  <= 8'h00;
         w_lane_q  <= 1'b0;
      end else if (clk_en_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[17:2];
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= scgwt_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_mapped(aw_idx_q) ? scgwt_pkg::RESP_OKAY
                                                 : scgwt_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         guard_lo_q <= scgwt_pkg::GLOW_RST;
         bgt_q  <= scgwt_pkg::BGT_RST;
         bw_q   <= 28'h0000000;
         cw_q   <= 16'h0000;
         at_q   <= 16'h0000;
         ctrl_q <= 2'h0;
      end else if (wr_en) begin
         case (aw_idx_q)
            scgwt_pkg::IDX_GLOW: guard_lo_q <= w_data_q;
            scgwt_pkg::IDX_BGT:  bgt_q <= w_data_q & scgwt_pkg::BGT_MASK;
            scgwt_pkg::IDX_BW3:  bw_q[27:24] <= w_data_q[3:0];
            scgwt_pkg::IDX_BW2:  bw_q[23:16] <= w_data_q;
            scgwt_pkg::IDX_BW1:  bw_q[15:8] <= w_data_q;
            scgwt_pkg::IDX_BW0:  bw_q[7:0] <= w_data_q;
            scgwt_pkg::IDX_CWH:  cw_q[15:8] <= w_data_q;
            scgwt_pkg::IDX_CWL:  cw_q[7:0] <= w_data_q;
            scgwt_pkg::IDX_ATH:  at_q[15:8] <= w_data_q;
            scgwt_pkg::IDX_ATL:  at_q[7:0] <= w_data_q;
            scgwt_pkg::IDX_CTRL: ctrl_q <= w_data_q[1:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (ar_idx)
         scgwt_pkg::IDX_GLOW: rd_mux[7:0] = guard_lo_q;
         scgwt_pkg::IDX_BGT:  rd_mux[7:0] = bgt_q;
         scgwt_pkg::IDX_BW3:  rd_mux[3:0] = bw_q[27:24];
         scgwt_pkg::IDX_BW2:  rd_mux[7:0] = bw_q[23:16];
         scgwt_pkg::IDX_BW1:  rd_mux[7:0] = bw_q[15:8];
         scgwt_pkg::IDX_BW0:  rd_mux[7:0] = bw_q[7:0];
         scgwt_pkg::IDX_CWH:  rd_mux[7:0] = cw_q[15:8];
         scgwt_pkg::IDX_CWL:  rd_mux[7:0] = cw_q[7:0];
         scgwt_pkg::IDX_ATH:  rd_mux[7:0] = at_q[15:8];
         scgwt_pkg::IDX_ATL:  rd_mux[7:0] = at_q[7:0];
         scgwt_pkg::IDX_CTRL: rd_mux[1:0] = ctrl_q;
         scgwt_pkg::IDX_STAT: rd_mux[2:0] = flags_q;
         default: ;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= scgwt_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= reg_mapped(ar_idx) ? scgwt_pkg::RESP_OKAY
                                               : scgwt_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit guard

   logic [8:0] guard_cnt_q;
   logic [8:0] guard9;
   logic [8:0] guard_min;
   logic [8:0] guard_lim;
   logic       brk_hold_q;

   // top bit from the block guard register
   assign guard9    = {bgt_q[scgwt_pkg::BGT_TOP_BIT], guard_lo_q};
   // mode floor on the programmed value
   assign guard_min = mode_t1 ? scgwt_pkg::GUARD_T1_MIN : scgwt_pkg::GUARD_T0_MIN;
   assign guard_lim = (guard9 < guard_min) ? guard_min : guard9;
   // hold off until the guard has elapsed
   assign tx_allow_o = (guard_cnt_q >= guard_lim) & ~brk_hold_q;

   // guard counts ETUs from each sent start bit; saturates so idle stays ready
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         guard_cnt_q <= scgwt_pkg::GUARD_SAT;
      end else if (tx_go) begin
         guard_cnt_q <= 9'h000;
      end else if (etu_tick && guard_cnt_q != scgwt_pkg::GUARD_SAT) begin
         guard_cnt_q <= guard_cnt_q + 9'h001;
      end
   end

   // break in T=0 postpones until the next ETU tick after it ends
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         brk_hold_q <= 1'b0;
      end else if (clk_en_i) begin
         if (evt_i.brk && !mode_t1) begin
            brk_hold_q <= 1'b1;
         end else if (etu_tick) begin
            brk_hold_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block or work wait timer

   logic        wait_run_q;
   logic [28:0] wait_cnt_q;
   logic        wait_rst;
   logic        wait_exp;

   // restart source depends on the mode
   assign wait_rst = mode_t1 ? tx_go : (tx_go | rx_go);
   // full 28-bit compare, counter one bit wider to reach past it
   assign wait_exp = clk_en_i & wait_run_q & (wait_cnt_q > {1'b0, bw_q});

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wait_run_q <= 1'b0;
         wait_cnt_q <= 29'h0000000;
      end else if (clk_en_i) begin
         wait_cnt_q <= tmr_next(wait_cnt_q, wait_rst, etu_tick & wait_run_q);
         if (wait_rst) begin
            wait_run_q <= 1'b1;
         // first received start ends a T=1 wait
         end else if ((mode_t1 && rx_go) || wait_exp) begin
            wait_run_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Character or initial wait timer

   logic        chr_run_q;
   logic [16:0] chr_cnt_q;
   logic        chr_exp;
   logic [28:0] chr_nxt;

   assign chr_exp = clk_en_i & chr_run_q & (chr_cnt_q > {1'b0, cw_q});
   assign chr_nxt = tmr_next({12'h000, chr_cnt_q}, rx_go, etu_tick & chr_run_q);

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chr_run_q <= 1'b0;
         chr_cnt_q <= 17'h00000;
      end else if (clk_en_i) begin
         // restart on each received start edge
         chr_cnt_q <= chr_nxt[16:0];
         if (rx_go) begin
            chr_run_q <= 1'b1;
         end else if (chr_exp) begin
            chr_run_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer-to-reset duration timer

   scgwt_pkg::scgwt_atr_st_t atr_st_q;
   logic [16:0]              atr_cnt_q;
   logic                     atr_exp;
   logic [28:0]              atr_nxt;

   assign atr_exp = clk_en_i & (atr_st_q == scgwt_pkg::ATR_RUN)
                    & (atr_cnt_q > {1'b0, at_q});
   assign atr_nxt = tmr_next({12'h000, atr_cnt_q},
                             atr_st_q == scgwt_pkg::ATR_ARMED,
                             etu_tick & (atr_st_q == scgwt_pkg::ATR_RUN));

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         atr_cnt_q <= 17'h00000;
      end else if (clk_en_i) begin
         // runs from first start edge on
         atr_cnt_q <= atr_nxt[16:0];
      end
   end

   // armed by the enable, started by the first start edge
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         atr_st_q <= scgwt_pkg::ATR_IDLE;
      end else if (clk_en_i) begin
         case (atr_st_q)
            scgwt_pkg::ATR_IDLE: begin
               if (rcv_en) begin
                  atr_st_q <= scgwt_pkg::ATR_ARMED;
               end
            end
            scgwt_pkg::ATR_ARMED: begin
               if (!rcv_en) begin
                  atr_st_q <= scgwt_pkg::ATR_IDLE;
               end else if (rx_go) begin
                  atr_st_q <= scgwt_pkg::ATR_RUN;
               end
            end
            scgwt_pkg::ATR_RUN: begin
               if (!rcv_en) begin
                  atr_st_q <= scgwt_pkg::ATR_IDLE;
               end else if (atr_exp) begin
                  atr_st_q <= scgwt_pkg::ATR_DONE;
               end
            end
            scgwt_pkg::ATR_DONE: begin
               if (!rcv_en) begin
                  atr_st_q <= scgwt_pkg::ATR_IDLE;
               end
            end
            default: atr_st_q <= scgwt_pkg::ATR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout flags

   logic [2:0] clr_mask;
   logic [2:0] set_mask;

   assign clr_mask = (wr_en && aw_idx_q == scgwt_pkg::IDX_STAT) ? w_data_q[2:0] : 3'h0;
   assign set_mask = {atr_exp, chr_exp, wait_exp};

   // sticky, write one clears, a new expiry wins over the clear
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_q <= '0;
      end else if (clk_en_i) begin
         flags_q <= (flags_q & ~clr_mask) | set_mask;
      end
   end

   assign flags_o = flags_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_atr_armed;
      atr_st_q == scgwt_pkg::ATR_ARMED && rcv_en;
   endsequence
   sequence s_rx_edge;
      rx_go;
   endsequence

   a_guard_t0_floor: assert property (
      (tx_allow_o && !mode_t1) |-> guard_cnt_q >= 9'h00C)
      else $error("T=0 transmit allowed before 12 ETUs");
   a_guard_t1_floor: assert property (
      (tx_allow_o && mode_t1) |-> guard_cnt_q >= 9'h00B)
      else $error("T=1 transmit allowed before 11 ETUs");
   a_guard_nine_bit: assert property (
      (tx_allow_o && bgt_q[7]) |-> guard_cnt_q[8])
      else $error("guard top bit ignored");
   a_guard_restart: assert property (
      tx_go |=> guard_cnt_q == 9'h000 ##1 !tx_allow_o)
      else $error("guard did not restart on transmit");
   a_break_hold: assert property (
      (clk_en_i && evt_i.brk && !mode_t1) |=> !tx_allow_o)
      else $error("break did not postpone transmit");
   a_wait_t1_stop: assert property (
      (mode_t1 && rx_go && !tx_go) |=> !wait_run_q)
      else $error("T=1 wait kept running after reception");
   a_wait_t0_any: assert property (
      (!mode_t1 && rx_go) |=> wait_run_q && wait_cnt_q == 29'h0000000)
      else $error("T=0 wait not restarted by received start");
   a_wait_tick: assert property (
      (wait_run_q && etu_tick && !wait_rst && !wait_exp)
      |=> wait_cnt_q == $past(wait_cnt_q) + 29'h0000001)
      else $error("wait timer missed an ETU tick");
   a_wait_flag: assert property (
      wait_exp |=> flags_q.wait_to && wait_run_q == $past(wait_rst))
      else $error("wait timeout not flagged");
   a_wait_limit: assert property (
      (wr_en && aw_idx_q == scgwt_pkg::IDX_BW3) |=> bw_q[27:24] == $past(w_data_q[3:0]))
      else $error("top wait byte not stored");
   a_chr_flag: assert property (
      (chr_run_q && chr_cnt_q > {1'b0, cw_q} && clk_en_i) |=> flags_q.chr_to)
      else $error("character wait timeout not flagged");
   a_atr_start: assert property (
      s_atr_armed ##0 s_rx_edge |=> atr_st_q == scgwt_pkg::ATR_RUN && atr_cnt_q == 17'h00000)
      else $error("answer timer did not start at first edge");
   a_atr_off: assert property (
      (clk_en_i && !rcv_en) |=> atr_st_q == scgwt_pkg::ATR_IDLE)
      else $error("answer timer running while disabled");
   a_atr_flag: assert property (
      atr_exp |=> flags_q.ans_to
                  && atr_st_q == ($past(rcv_en) ? scgwt_pkg::ATR_DONE : scgwt_pkg::ATR_IDLE))
      else $error("answer timeout not flagged");
   a_flag_hold: assert property (
      (flags_q.wait_to && clr_mask[0] == 1'b0) |=> flags_q.wait_to)
      else $error("wait flag lost without acknowledge");

endmodule : scgwt_timers

// file: sim/scgwt_card_model.sv
/*
 Card-side model: free-running ETU clock and reply start bits.
 Assumes tx start pulses arrive on core_clk_i from the bench.
*/
`timescale 1ns/10ps
module scgwt_card_model (
   input  wire logic       core_clk_i,
   input  wire logic       tx_start_i,
   input  wire logic [7:0] reply_etu_i,
   output logic            etu_clk_o,
   output logic            rx_start_o = 1'b0
);
   logic [7:0] cnt_q = '0;
   logic       etu_q = 1'b0;
   // Divider runs free; odd offset keeps phase unrelated
   initial begin
      etu_clk_o = 1'b0;
      #37;
      forever #200 etu_clk_o = ~etu_clk_o;
   end
   // reply after N ETUs, zero means mute card
   always @(posedge core_clk_i) begin
      etu_q      <= etu_clk_o;
      rx_start_o <= 1'b0;
      if (tx_start_i) begin
         cnt_q <= reply_etu_i;
      end else if (cnt_q != 8'h00 && etu_clk_o && !etu_q) begin
         cnt_q      <= cnt_q - 8'h01;
         rx_start_o <= (cnt_q == 8'h01);
      end
   end
endmodule : scgwt_card_model

// file: sim/test_smart_card_guard_wait_timers.sv
/*
 Self-checking bench for the guard and wait timers.
 Assumes the card model supplies ETU clock and reply start bits.
*/
`timescale 1ns/10ps
module test_smart_card_guard_wait_timers;
   logic clk = 0, rst = 1, etu, rxs, txs = 0, brk = 0, ce = 1;
   logic [3:0] ws = 4'hF;
   logic [17:0] aw_a = '0, ar_a = '0;
   logic [31:0] wd = '0, rd, d;
   logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, tx_ok;
   logic [1:0] b_rs, r_rs, rs;
   logic [7:0] reply = '0, sd = 8'h22;
   logic [15:0] ix [10] = '{16'hFE18, 16'hFE19, 16'hFE1A, 16'hFE1B, 16'hFE1C,
                            16'hFE1D, 16'hFE1F, 16'hFE20, 16'hFE17, 16'hFE16};
   logic [9:0] gt [4] = '{10'h005, 10'h205, 10'h014, 10'h104};
   scgwt_pkg::scgwt_flags_t fl;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
   ////////////////////////////////////////////////////////////////////
   scgwt_timers dut_u (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(ce),
      .etu_clk_i(etu), .evt_i({txs, rxs, brk}), .tx_allow_o(tx_ok),
      .flags_o(fl), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rs),
      .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
      .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(rd),
      .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
   scgwt_card_model card_u (.core_clk_i(clk), .tx_start_i(txs),
      .reply_etu_i(reply), .etu_clk_o(etu), .rx_start_o(rxs));
   initial forever #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   function logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function logic [7:0] rmask(input int i);
      return (i == 0) ? 8'h0F : (i == 9) ? 8'h9F : 8'hFF;
   endfunction : rmask
   function int gexp(input logic [9:0] c);
      int m;
      m = c[9] ? 11 : 12;
      return (c[8:0] < m) ? m : int'(c[8:0]);
   endfunction : gexp
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      aw_a <= {a, 2'b00};
      wd <= {24'h0, v};
      aw_v <= 1;
      w_v <= 1;
      b_r <= 1;
      do begin
         @(posedge clk);
         if (aw_rdy) aw_v <= 0;
         if (w_rdy) w_v <= 0;
      end while (!b_v);
      rs = b_rs;
      b_r <= 0;
   endtask : wr
   task rdr(input logic [15:0] a);
      @(posedge clk);
      ar_a <= {a, 2'b00};
      ar_v <= 1;
      r_r <= 1;
      do begin
         @(posedge clk);
         if (ar_rdy) ar_v <= 0;
      end while (!r_v);
      d = rd;
      rs = r_rs;
      r_r <= 0;
   endtask : rdr
   task tx;
      @(posedge clk);
      txs <= 1;
      @(posedge clk);
      txs <= 0;
   endtask : tx
   task conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude;
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 10; i++) begin
         rdr(ix[i]);
         chk(d, (i == 8) ? 32'h0C : (i == 9) ? 32'h10 : 32'h0);
         sd = lfsr(sd);
         wr(ix[i], sd);
         chk(rs, 2'h0);
         rdr(ix[i]);
         chk(d, {24'h0, sd & rmask(i)});
      end
      rdr(16'hFE1E);
      chk(d, 32'h0);
      chk(rs, 2'h2);
      // Lane 0 strobe low leaves the register as it was
      ws <= 4'h0;
      wr(ix[9], ~sd);
      chk(rs, 2'h0);
      ws <= 4'hF;
      rdr(ix[9]);
      chk(d, {24'h0, sd & rmask(9)});
      wr(16'hFE1E, 8'h55);
      chk(rs, 2'h2);
      for (int i = 0; i < 4; i++) begin
         wr(16'hFE30, {7'h0, gt[i][9]});
         wr(16'hFE16, {gt[i][8], 7'h0});
         wr(16'hFE17, gt[i][7:0]);
         n = gexp(gt[i]);
         tx;
         repeat (8 * n - 12) @(posedge clk);
         chk(tx_ok, 1'b0);
         repeat (24) @(posedge clk);
         chk(tx_ok, 1'b1);
      end
      wr(16'hFE17, 8'h00);
      wr(16'hFE16, 8'h00);
      wr(16'hFE30, 8'h00);
      tx;
      repeat (84) @(posedge clk);
      chk(tx_ok, 1'b0);
      repeat (28) @(posedge clk);
      chk(tx_ok, 1'b1);
      tx;
      ce <= 0;
      repeat (200) @(posedge clk);
      chk(tx_ok, 1'b0);
      ce <= 1;
      repeat (112) @(posedge clk);
      chk(tx_ok, 1'b1);
      brk <= 1;
      repeat (4) @(posedge clk);
      chk(tx_ok, 1'b0);
      brk <= 0;
      repeat (20) @(posedge clk);
      chk(tx_ok, 1'b1);
      foreach (ix[i]) begin
         if (i < 8) begin
            wr(ix[i], (i == 3) ? 8'h14 : (i == 5) ? 8'h06 : (i == 7) ? 8'h04 : 8'h00);
         end
      end
      wr(16'hFE30, 8'h03);
      reply <= 8'd2;
      tx;
      wr(16'hFE31, 8'h07);
      repeat (24) @(posedge clk);
      chk(fl, 3'b000);
      repeat (88) @(posedge clk);
      chk(fl, 3'b110);
      wr(16'hFE31, 8'h07);
      repeat (112) @(posedge clk);
      chk(fl, 3'b000);
      wr(16'hFE30, 8'h01);
      reply <= 8'd0;
      tx;
      repeat (144) @(posedge clk);
      chk(fl, 3'b000);
      repeat (48) @(posedge clk);
      chk(fl, 3'b001);
      wr(16'hFE30, 8'h00);
      reply <= 8'd6;
      tx;
      wr(16'hFE31, 8'h07);
      repeat (184) @(posedge clk);
      chk(fl.wait_to, 1'b0);
      repeat (56) @(posedge clk);
      chk(fl.wait_to, 1'b1);
      conclude;
   end
endmodule : test_smart_card_guard_wait_timers
